// [rtl/asf_pkg.sv]
// Purpose: constants for the strobe fifo host controller
// Assumes: 100 MHz clk, 10 ns period
// Notes: pin timing figures are held in ns and turned into cycles here
package asf_pkg;
    localparam int ASF_WIDTH = 8;
    localparam int ASF_CLK_NS = 10;
    // least strobe high and low times, and the first-pop guard delay
    localparam int ASF_STROBE_HIGH_NS = 20;
    localparam int ASF_STROBE_LOW_NS = 45;
    localparam int ASF_FIRST_POP_NS = 40;
    localparam int ASF_RESET_NS = 40;
    localparam int ASF_RESET_TO_SI_NS = 40;
    localparam int ASF_HIGH_CYC = (ASF_STROBE_HIGH_NS + ASF_CLK_NS - 1)
        / ASF_CLK_NS;
    localparam int ASF_LOW_CYC = (ASF_STROBE_LOW_NS + ASF_CLK_NS - 1)
        / ASF_CLK_NS;
    localparam int ASF_GUARD_CYC = (ASF_FIRST_POP_NS + ASF_CLK_NS - 1)
        / ASF_CLK_NS;
    localparam int ASF_RST_CYC = (ASF_RESET_NS + ASF_CLK_NS - 1)
        / ASF_CLK_NS;
    localparam int ASF_RSI_CYC = (ASF_RESET_TO_SI_NS + ASF_CLK_NS - 1)
        / ASF_CLK_NS;
    localparam int ASF_CNT_W = 4;
    localparam logic [ASF_CNT_W-1:0] ASF_CNT_ZERO = 4'h0;
    typedef enum logic [3:0] {
        ASF_W_IDLE = 4'b0001,
        ASF_W_HIGH = 4'b0010,
        ASF_W_LOW = 4'b0100,
        ASF_W_RST = 4'b1000
    } asf_wstate_type;
    typedef enum logic [3:0] {
        ASF_R_IDLE = 4'b0001,
        ASF_R_GUARD = 4'b0010,
        ASF_R_HIGH = 4'b0100,
        ASF_R_LOW = 4'b1000
    } asf_rstate_type;
endpackage

// [rtl/asf_skid.sv]
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: in_ready comes from a register, so a stall never drops a word
`timescale 1ns/10ps
module asf_skid
    import asf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [ASF_WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [ASF_WIDTH-1:0] out_data
);
    logic [ASF_WIDTH-1:0] mem_reg [2];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // asf_skid

// [rtl/asf_host.sv]
// Purpose: host that drives a strobe fifo: writer side and reader side
// Assumes: fifo pins are synchronous to clk; one fifo or an anded group
// Notes: reader uses the hold-until-ready-falls handshake plus a guard
//
// How it works
// RQ1 - fifo keeps separate read and write pointers
// RQ2 - fifo flags space and valid data honestly
// RQ3 - fifo output enable allows shared bus
// RQ4 - output enable low drives, high floats
// RQ5 - host pulses clear before any strobe
// RQ6 - clear empties fifo, flags idle values
// RQ7 - shift-in held through clear stores word
// RQ8 - fifo captures word on shift-in rise
// RQ9 - shift-in fall advances write, frees flag
// RQ10 - full fifo keeps space flag low
// RQ11 - shift-out fall advances read pointer
// RQ12 - shift-out rise pulls output-ready low
// RQ13 - reader captures data on shift-out rise
// RQ14 - empty fifo bubbles first word out
// RQ15 - freed space bubbles to input side
// RQ16 - first pop waits after ready rises
// RQ17 - hold shift-out high until ready falls
// RQ18 - empty fifo leaves last word, ready low
// RQ19 - ready high means stable valid data
// RQ20 - shift-out held high pulses ready once
// RQ21 - cascades chain ready to shift-in
// RQ22 - parallel flags are anded externally
// RQ23 - synchronous design, parameters, no lost edge
`timescale 1ns/10ps
module asf_host
    import asf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start_clear,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [ASF_WIDTH-1:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [ASF_WIDTH-1:0] rd_data,
    output logic busy,
    output logic clear_n,
    output logic shift_in,
    output logic [ASF_WIDTH-1:0] write_word,
    input wire logic space_avail_flag,
    output logic shift_out,
    output logic out_enable_n,
    input wire logic out_ready_flag,
    input wire logic [ASF_WIDTH-1:0] read_word
);
    // ============================================================
    // writer side
    asf_wstate_type wstate_reg;
    logic [ASF_CNT_W-1:0] wcnt_reg;
    logic [ASF_CNT_W-1:0] rsi_reg;
    logic wr_ready_reg;

    function automatic logic [ASF_CNT_W-1:0] cyc(input int n);
        cyc = ASF_CNT_W'(n);
    endfunction

    // a word is taken from the user only when the fifo has room
    assign wr_ready = wr_ready_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            wstate_reg <= ASF_W_RST;
            wcnt_reg <= cyc(ASF_RST_CYC);
            rsi_reg <= cyc(ASF_RSI_CYC);
            clear_n <= 1'b0;
            shift_in <= 1'b0;
            write_word <= '0;
            wr_ready_reg <= 1'b0;
        end else begin
            wr_ready_reg <= 1'b0;
            case (wstate_reg)
                ASF_W_RST: begin
                    // shift-in kept low, nothing stored [RQ5] [RQ7]
                    clear_n <= 1'b0;
                    shift_in <= 1'b0;
                    if (wcnt_reg != ASF_CNT_ZERO) begin
                        wcnt_reg <= wcnt_reg - 1'b1;
                    end else begin
                        clear_n <= 1'b1;
                        rsi_reg <= cyc(ASF_RSI_CYC);
                        wstate_reg <= ASF_W_IDLE;
                    end
                end
                ASF_W_IDLE: begin
                    if (rsi_reg != ASF_CNT_ZERO) begin
                        rsi_reg <= rsi_reg - 1'b1;
                    end else if (start_clear) begin
                        wcnt_reg <= cyc(ASF_RST_CYC);
                        clear_n <= 1'b0;
                        wstate_reg <= ASF_W_RST;
                    end else if (wr_valid && !wr_ready_reg &&
                                 space_avail_flag) begin
                        // room flag (anded) [RQ2] [RQ8] [RQ10] [RQ22]
                        wr_ready_reg <= 1'b1;
                        write_word <= wr_data;
                        shift_in <= 1'b1;
                        wcnt_reg <= cyc(ASF_HIGH_CYC);
                        wstate_reg <= ASF_W_HIGH;
                    end
                end
                ASF_W_HIGH: begin
                    if (wcnt_reg != ASF_CNT_ZERO) begin
                        wcnt_reg <= wcnt_reg - 1'b1;
                    end else begin
                        // falling edge advances the write pointer [RQ9]
                        shift_in <= 1'b0;
                        wcnt_reg <= cyc(ASF_LOW_CYC);
                        wstate_reg <= ASF_W_LOW;
                    end
                end
                ASF_W_LOW: begin
                    // word is held past the fall for data hold
                    if (wcnt_reg != ASF_CNT_ZERO) begin
                        wcnt_reg <= wcnt_reg - 1'b1;
                    end else begin
                        wstate_reg <= ASF_W_IDLE;
                    end
                end
                default: begin
                    wstate_reg <= ASF_W_RST;
                end
            endcase
        end
    end

    // ============================================================
    // reader side
    asf_rstate_type rstate_reg;
    logic [ASF_CNT_W-1:0] rcnt_reg;
    logic or_seen_reg;
    logic cap_valid;
    logic cap_ready;
    logic [ASF_WIDTH-1:0] cap_data_reg;
    logic cap_valid_reg;
    logic [ASF_WIDTH-1:0] skid_data;
    logic skid_valid;
    logic clear_go;

    assign cap_valid = cap_valid_reg;
    // a new clear floats the bus and drops shift-out at its first edge
    assign clear_go = (wstate_reg == ASF_W_IDLE) &&
        (rsi_reg == ASF_CNT_ZERO) && start_clear;

    always_ff @(posedge clk) begin
        if (rst) begin
            rstate_reg <= ASF_R_IDLE;
            rcnt_reg <= ASF_CNT_ZERO;
            or_seen_reg <= 1'b0;
            shift_out <= 1'b0;
            out_enable_n <= 1'b1;
            cap_data_reg <= '0;
            cap_valid_reg <= 1'b0;
        end else begin
            // single host: drive the bus outside a clear [RQ3] [RQ4]
            out_enable_n <= !clear_n || clear_go;
            if (cap_valid_reg && cap_ready) begin
                cap_valid_reg <= 1'b0;
            end
            if (!clear_n || clear_go) begin
                rstate_reg <= ASF_R_IDLE;
                shift_out <= 1'b0;
                or_seen_reg <= 1'b0;
            end else begin
                case (rstate_reg)
                    ASF_R_IDLE: begin
                        // first ready after empty waits [RQ16] [RQ14]
                        if (out_ready_flag && !or_seen_reg) begin
                            or_seen_reg <= 1'b1;
                            rcnt_reg <= cyc(ASF_GUARD_CYC);
                            rstate_reg <= ASF_R_GUARD;
                        end else if (out_ready_flag && !cap_valid_reg) begin
                            rstate_reg <= ASF_R_GUARD;
                            rcnt_reg <= ASF_CNT_ZERO;
                        end else if (!out_ready_flag) begin
                            // empty: ignore the stale word on the bus [RQ18]
                            or_seen_reg <= 1'b0;
                        end
                    end
                    ASF_R_GUARD: begin
                        if (rcnt_reg != ASF_CNT_ZERO) begin
                            rcnt_reg <= rcnt_reg - 1'b1;
                        end else if (!cap_valid_reg && out_ready_flag) begin
                            // take the word at the rising strobe [RQ13] [RQ19]
                            cap_data_reg <= read_word;
                            cap_valid_reg <= 1'b1;
                            shift_out <= 1'b1;
                            rcnt_reg <= cyc(ASF_HIGH_CYC);
                            rstate_reg <= ASF_R_HIGH;
                        end
                    end
                    ASF_R_HIGH: begin
                        // hold until ready drops [RQ17] [RQ12] [RQ21]
                        if (rcnt_reg != ASF_CNT_ZERO) begin
                            rcnt_reg <= rcnt_reg - 1'b1;
                        end else if (!out_ready_flag) begin
                            // fall advances the read pointer [RQ11] [RQ20]
                            shift_out <= 1'b0;
                            rcnt_reg <= cyc(ASF_LOW_CYC);
                            rstate_reg <= ASF_R_LOW;
                        end
                    end
                    ASF_R_LOW: begin
                        if (rcnt_reg != ASF_CNT_ZERO) begin
                            rcnt_reg <= rcnt_reg - 1'b1;
                        end else begin
                            or_seen_reg <= 1'b1;
                            rstate_reg <= ASF_R_IDLE;
                        end
                    end
                    default: begin
                        rstate_reg <= ASF_R_IDLE;
                    end
                endcase
            end
        end
    end

    // buffer in the data path; a stalled user holds off the next pop [RQ23]
    asf_skid u_skid (
        .clk(clk),
        .rst(rst),
        .in_valid(cap_valid),
        .in_ready(cap_ready),
        .in_data(cap_data_reg),
        .out_valid(skid_valid),
        .out_ready(rd_ready && !rd_valid),
        .out_data(skid_data)
    );

    // user side output register
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_data <= '0;
            busy <= 1'b1;
        end else begin
            busy <= (wstate_reg == ASF_W_RST);
            if (rd_valid && rd_ready) begin
                rd_valid <= 1'b0;
            end else if (!rd_valid && skid_valid && rd_ready) begin
                rd_valid <= 1'b1;
                rd_data <= skid_data;
            end
        end
    end
endmodule // asf_host

// [verif/asf_fifo_model.sv]
// Purpose: behavioural strobe fifo, four words deep, on the far side
// Assumes: host strobes are synchronous to clk
// Notes: pointers are unknown until the first clear, so early strobes show
`timescale 1ns/10ps
module asf_fifo_model
    import asf_pkg::*;
(
    input wire logic clk,
    input wire logic clear_n,
    input wire logic shift_in,
    input wire logic [ASF_WIDTH-1:0] write_word,
    output logic space_avail_flag,
    input wire logic shift_out,
    input wire logic out_enable_n,
    output logic out_ready_flag,
    output logic [ASF_WIDTH-1:0] read_word
);
    // ==========================================
    // store and pointers
    logic [ASF_WIDTH-1:0] mem [4];
    logic [ASF_WIDTH-1:0] dout;
    logic [2:0] wp, rp, cnt;
    logic si_q, so_q, took, pend;
    logic clr_q, was_empty;
    assign cnt = wp - rp;
    // a floated bus shows the inverse, not a stale copy
    assign read_word = out_enable_n ? ~dout : dout;
    always_ff @(posedge clk) begin
        si_q <= shift_in;
        so_q <= shift_out;
        clr_q <= clear_n;
        if (!clear_n) begin
            was_empty <= 1'b1;
            wp <= 3'h0;
            rp <= 3'h0;
            took <= 1'b0;
            pend <= 1'b0;
            dout <= '0;
            out_ready_flag <= 1'b0;
            space_avail_flag <= 1'b1;
        end else begin
            if (shift_in && !si_q && cnt != 3'h4) begin
                mem[wp[1:0]] <= write_word;
                took <= 1'b1;
            end
            // shift-in already high as the clear ends stores the word
            if (!clr_q && shift_in) begin
                mem[wp[1:0]] <= write_word;
                took <= 1'b1;
            end
            if (!shift_in && si_q && took) begin
                wp <= wp + 3'h1;
                took <= 1'b0;
            end
            if (shift_out && out_ready_flag)
                pend <= 1'b1;
            if (!shift_out && so_q && pend) begin
                rp <= rp + 3'h1;
                pend <= 1'b0;
            end
            if (cnt != 3'h0 && !pend)
                dout <= mem[rp[1:0]];
            was_empty <= cnt == 3'h0;
            // held shift-out lets a bubbled word pulse ready once
            out_ready_flag <= cnt != 3'h0 && !pend &&
                (!shift_out || was_empty);
            space_avail_flag <= !shift_in && !took && cnt != 3'h4;
        end
    end
endmodule // asf_fifo_model

// [verif/asf_host_asserts.sv]
// Purpose: pin timing checks on the strobe fifo host
// Assumes: one clock, rst synchronous active high
// Notes: counts are the host's chosen cycle figures
`timescale 1ns/10ps
module asf_host_asserts
    import asf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic busy,
    input wire logic clear_n,
    input wire logic shift_in,
    input wire logic [ASF_WIDTH-1:0] write_word,
    input wire logic [ASF_WIDTH-1:0] wr_data,
    input wire logic wr_ready,
    input wire logic space_avail_flag,
    input wire logic shift_out,
    input wire logic out_enable_n,
    input wire logic out_ready_flag
);
    // ==========================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_NO_STROBE_CLR: assert property (
        busy |-> !shift_in && !shift_out)
        else $error("strobe while clearing");
    AST_OE_CLR: assert property (
        !clear_n |-> out_enable_n)
        else $error("outputs enabled in clear");
    AST_CLR_WAIT: assert property (
        $rose(clear_n) |-> !shift_in [*4])
        else $error("shift-in too soon after clear");
    AST_SI_SPACE: assert property (
        $rose(shift_in) |-> $past(space_avail_flag))
        else $error("shift-in without space");
    AST_WR_PAIR: assert property (
        wr_ready |-> $rose(shift_in) && write_word == wr_data)
        else $error("word and strobe apart");
    AST_SI_HIGH: assert property (
        $rose(shift_in) |-> shift_in [*3] ##1 !shift_in)
        else $error("shift-in high time");
    AST_SO_HAND: assert property (
        $fell(shift_out) |-> !$past(out_ready_flag))
        else $error("shift-out dropped early");
    AST_SO_FLAG: assert property (
        $rose(shift_out) |-> $past(out_ready_flag))
        else $error("pop with no word");
    cover property (wr_ready && !space_avail_flag);
    cover property ($fell(shift_out));
    cover property ($rose(clear_n));
endmodule // asf_host_asserts

bind asf_host asf_host_asserts u_asf_host_asserts (
    .clk(clk), .rst(rst), .busy(busy), .clear_n(clear_n),
    .shift_in(shift_in), .write_word(write_word), .wr_data(wr_data),
    .wr_ready(wr_ready), .space_avail_flag(space_avail_flag),
    .shift_out(shift_out), .out_enable_n(out_enable_n),
    .out_ready_flag(out_ready_flag)
);

// [verif/tb_top.sv]
// Purpose: self-checking bench for the strobe fifo host
// Assumes: a four-word fifo model on the far side
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/10ps
module tb_top
    import asf_pkg::*;
;
    typedef struct {
        logic [ASF_WIDTH-1:0] din;
        logic [ASF_WIDTH-1:0] dout;
    } asf_row_type;
    logic clk, rst, start_clear, wr_valid, wr_ready, rd_valid, rd_ready;
    logic busy, clear_n, shift_in, space_avail_flag, shift_out;
    logic out_enable_n, out_ready_flag;
    logic [ASF_WIDTH-1:0] wr_data, rd_data, write_word, read_word;
    int num_errors = 0;
    int n_compared = 0;
    asf_row_type rows [4] = '{'{8'h81, 8'h81}, '{8'hff, 8'hff},
        '{8'h5a, 8'h5a}, '{8'ha5, 8'ha5}};
    asf_host u_asf_host (
        .clk(clk), .rst(rst), .start_clear(start_clear),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .busy(busy), .clear_n(clear_n), .shift_in(shift_in),
        .write_word(write_word), .space_avail_flag(space_avail_flag),
        .shift_out(shift_out), .out_enable_n(out_enable_n),
        .out_ready_flag(out_ready_flag), .read_word(read_word)
    );
    asf_fifo_model u_asf_fifo_model (
        .clk(clk), .clear_n(clear_n), .shift_in(shift_in),
        .write_word(write_word), .space_avail_flag(space_avail_flag),
        .shift_out(shift_out), .out_enable_n(out_enable_n),
        .out_ready_flag(out_ready_flag), .read_word(read_word)
    );
    // ==========================================
    // tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic tick(inout int n);
        @(posedge clk);
        #1;
        n++;
        if (n > 3000) begin
            chk(8'h00, 8'h01);
            test_done();
        end
    endtask
    task automatic push(input logic [7:0] d);
        int n = 0;
        tick(n);
        wr_data = d;
        wr_valid = 1'b1;
        while (wr_ready !== 1'b1)
            tick(n);
        tick(n);
        wr_valid = 1'b0;
    endtask
    task automatic pop(input logic [7:0] exp);
        int n = 0;
        tick(n);
        rd_ready = 1'b1;
        while (rd_valid !== 1'b1)
            tick(n);
        chk(rd_data, exp);
        tick(n);
        rd_ready = 1'b0;
    endtask
    // ==========================================
    // sequence
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        int n;
        rst = 1'b1;
        start_clear = 1'b0;
        wr_valid = 1'b0;
        wr_data = 8'h00;
        rd_ready = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        foreach (rows[i]) begin
            push(rows[i].din);
            pop(rows[i].dout);
        end
        $display("rows done");
        // reader stalls for 600 cycles, checks the fifo is full, then drains in order
        fork
            for (int i = 0; i < 12; i++)
                push(8'(i + 16));
            begin
                repeat (600) @(posedge clk);
                #1;
                chk(8'(space_avail_flag), 8'h00);
                chk(8'(out_enable_n), 8'h00);
                for (int i = 0; i < 12; i++)
                    pop(8'(i + 16));
            end
        join
        $display("full fifo done");
        n = 0;
        tick(n);
        start_clear = 1'b1;
        tick(n);
        start_clear = 1'b0;
        while (clear_n !== 1'b0)
            tick(n);
        chk(8'(out_enable_n), 8'h01);
        // busy is registered one cycle behind the clear strobe
        tick(n);
        chk(8'(busy), 8'h01);
        push(8'hc3);
        pop(8'hc3);
        $display("clear done");
        tick(n);
        rst = 1'b1;
        tick(n);
        chk({5'h00, clear_n, busy, rd_valid}, 8'h02);
        tick(n);
        rst = 1'b0;
        push(8'h3c);
        pop(8'h3c);
        $display("reset done");
        test_done();
    end
endmodule // tb_top
